// file: shared/tcd_pkg.sv
// What this block does
// [RQ1] take bus cycles ahead of the cpu
// [RQ2] move one byte or word per transfer
// [RQ3] request from software trigger or peripheral
// [RQ4] ignore interrupt masks, change no interrupt state
// [RQ5] enabled channel transfers once per request
// [RQ6] requests arriving while pending may merge
// [RQ7] 1m byte space, fixed or forward ends
// [RQ8] never both source and destination forward
// [RQ9] never touch the 00020 to 0003f range
// [RQ10] counter of 64k units per run
// [RQ11] pins, timers, serial, bus, converter, overlay sources
// [RQ12] only first slicer may request transfers
// [RQ13] channel zero wins simultaneous requests
// [RQ14] single mode underflow clears the enable
// [RQ15] repeat mode underflow reloads the counter
// [RQ16] first transfer loads pointer and counter
// [RQ17] fixed pointers writable only while disabled
// [RQ18] enabled forward pointer reads live value
// [RQ19] request bit sets always, clears at start
// [RQ20] rewriting enable restarts the channel
// [RQ21] pointer steps by unit, counter decrements
`default_nettype none
package tcd_pkg;
  localparam int          ADDR_W      = 20;
  localparam int          DATA_W      = 16;
  localparam int          CNT_W       = 16;
  localparam int          REG_AW      = 8;
  localparam int          NUM_CH      = 2;
  // per channel register offsets, channel one sits one stride higher
  localparam logic [7:0]  OFF_SRC     = 8'h00;
  localparam logic [7:0]  OFF_DST     = 8'h04;
  localparam logic [7:0]  OFF_RELOAD  = 8'h08;
  localparam logic [7:0]  OFF_COUNT   = 8'h0c;
  localparam logic [7:0]  OFF_CTRL    = 8'h10;
  localparam logic [7:0]  OFF_SEL     = 8'h14;
  localparam logic [7:0]  CH_STRIDE   = 8'h20;
  // control register bits
  localparam int          B_EN        = 0;
  localparam int          B_REPEAT    = 1;
  localparam int          B_BYTE      = 2;
  localparam int          B_SRC_FWD   = 3;
  localparam int          B_DST_FWD   = 4;
  localparam int          B_REQ       = 5;
  localparam int          B_SWTRIG    = 6;
  localparam int          CTRL_W      = 7;
  // protected range of the controller's own registers
  localparam logic [19:0] PROT_LO     = 20'h00020;
  localparam logic [19:0] PROT_HI     = 20'h0003f;
  // request source select codes
  localparam int          SEL_W       = 5;
  localparam logic [4:0]  SRC_SOFT    = 5'h00;
  localparam logic [4:0]  SRC_PA_FALL = 5'h01;
  localparam logic [4:0]  SRC_PA_BOTH = 5'h02;
  localparam logic [4:0]  SRC_PB_FALL = 5'h03;
  localparam int          SRC_IRQ0    = 4;
  localparam int          NUM_IRQ     = 19;
  localparam int          NUM_SRC     = SRC_IRQ0 + NUM_IRQ;
  localparam logic [19:0] STEP_BYTE   = 20'h00001;
  localparam logic [19:0] STEP_WORD   = 20'h00002;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } tcd_state_type;
endpackage : tcd_pkg
`default_nettype wire

// file: hdl/tcd_dma.sv
`timescale 1ns/10ps
`default_nettype none
module tcd_dma
  import tcd_pkg::*;
#(
  parameter logic [NUM_SRC-1:0] CH0_SRC_MASK = '1,
  parameter logic [NUM_SRC-1:0] CH1_SRC_MASK = '1
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // register port
  input  wire logic [REG_AW-1:0]  reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  // request sources
  input  wire logic               ext_interrupt_pin_a,
  input  wire logic               ext_interrupt_pin_b,
  input  wire logic [NUM_IRQ-1:0] periph_irq,
  // shared memory bus
  output logic                    cpu_hold,
  output logic      [ADDR_W-1:0]  mem_addr,
  output logic      [DATA_W-1:0]  mem_wdata,
  output logic                    mem_rd,
  output logic                    mem_wr,
  output logic                    mem_byte,
  input  wire logic [DATA_W-1:0]  mem_rdata,
  input  wire logic               mem_ack
);

  // the engine owns the bus for one unit at a time; the cpu only waits
  // while cpu_hold is high, so a stalled memory stalls the cpu as well
  // both channels share one engine; units are never interleaved

  // does an address fall in the protected register range
  function automatic logic is_prot(input logic [ADDR_W-1:0] a);
    is_prot = (a >= PROT_LO) && (a <= PROT_HI);
  endfunction : is_prot

  // which channel and offset a register address selects
  function automatic logic hit(input logic [REG_AW-1:0] a, input int ch,
                               input logic [7:0] off);
    hit = (a == off + (ch[0] ? CH_STRIDE : 8'h00));
  endfunction : hit

  // channel state
  logic [ADDR_W-1:0] src_ptr [NUM_CH];
  logic [ADDR_W-1:0] dst_ptr [NUM_CH];
  logic [ADDR_W-1:0] fwd_ptr [NUM_CH];
  logic [CNT_W-1:0]  reload  [NUM_CH];
  logic [CNT_W-1:0]  count   [NUM_CH];
  logic [SEL_W-1:0]  sel     [NUM_CH];
  logic [NUM_CH-1:0] en;
  logic [NUM_CH-1:0] repeat_mode;
  logic [NUM_CH-1:0] byte_unit;
  logic [NUM_CH-1:0] src_fwd;
  logic [NUM_CH-1:0] dst_fwd;
  logic [NUM_CH-1:0] req;
  logic [NUM_CH-1:0] first;
  logic [NUM_CH-1:0] trig;
  logic [NUM_CH-1:0] start;
  logic [NUM_CH-1:0] done;

  // transfer engine state
  // cur_ch remembers whose pointer and counter advance at done
  tcd_state_type     state;
  logic              cur_ch;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] data_hold;
  logic              pick_ch;
  logic              pick_any;
  logic [ADDR_W-1:0] pick_fwd;
  logic [ADDR_W-1:0] pick_src;
  logic [ADDR_W-1:0] pick_dst;

  // pin synchronisers and agreed levels
  logic [2:0]        sync_a;
  logic [2:0]        sync_b;
  logic              lvl_a;
  logic              lvl_b;
  logic              fall_a;
  logic              rise_a;
  logic              fall_b;
  logic [NUM_SRC-1:0] events;

  // pins are asynchronous: three stages keep metastability away from the
  // request logic, and a level counts only once two stages agree, which
  // also drops single-cycle glitches
  // three flop synchronisers on both pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
    end else begin
      sync_a <= {sync_a[1:0], ext_interrupt_pin_a};
      sync_b <= {sync_b[1:0], ext_interrupt_pin_b};
    end
  end

  // a level change counts once the second and third stage agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lvl_a <= 1'b1;
      lvl_b <= 1'b1;
    end else begin
      if (sync_a[1] == sync_a[2]) lvl_a <= sync_a[2];
      if (sync_b[1] == sync_b[2]) lvl_b <= sync_b[2];
    end
  end

  assign fall_a = (sync_a[1] == sync_a[2]) && lvl_a && !sync_a[2];
  assign rise_a = (sync_a[1] == sync_a[2]) && !lvl_a && sync_a[2];
  assign fall_b = (sync_b[1] == sync_b[2]) && lvl_b && !sync_b[2];

  // periph_irq pulses come from this clock domain and need no synchroniser
  // request source vector; slot zero is software only
  // no second slicer input exists in this vector (see [RQ12])
  assign events = {periph_irq, fall_b, fall_a | rise_a, fall_a, 1'b0}; // see [RQ11]

  // a channel that loses arbitration keeps its request bit set and is
  // served once the engine is idle again; channel zero wins a tie
  // channel priority and pointer selection for the next transfer
  always_comb begin
    pick_any = 1'b0;
    pick_ch  = 1'b0;
    if (req[0] && en[0]) begin // see [RQ13]
      pick_any = 1'b1;
      pick_ch  = 1'b0;
    end else if (req[1] && en[1]) begin // see [RQ5]
      pick_any = 1'b1;
      pick_ch  = 1'b1;
    end
    // first transfer after activation uses the programmed pointer
    if (first[pick_ch]) begin // see [RQ16]
      pick_fwd = src_fwd[pick_ch] ? src_ptr[pick_ch] : dst_ptr[pick_ch];
    end else begin
      pick_fwd = fwd_ptr[pick_ch];
    end
    pick_src = src_fwd[pick_ch] ? pick_fwd : src_ptr[pick_ch]; // see [RQ7]
    pick_dst = dst_fwd[pick_ch] ? pick_fwd : dst_ptr[pick_ch];
  end

  // start clears the request in the cycle the engine leaves idle;
  // done marks the edge at which pointer and counter advance
  // start and completion pulses per channel
  always_comb begin
    start = '0;
    done  = '0;
    if (state == ST_IDLE && pick_any) start[pick_ch] = 1'b1;
    if (state == ST_WRITE && (mem_ack || !mem_wr)) done[cur_ch] = 1'b1;
  end

  // one copy of the register set per channel, addressed by stride
  // per channel registers
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic wr_src;
    logic wr_dst;
    logic wr_ctrl;
    logic [NUM_SRC-1:0] mask;
    assign mask    = (c == 0) ? CH0_SRC_MASK : CH1_SRC_MASK;
    assign wr_src  = reg_wr && hit(reg_addr, c, OFF_SRC);
    assign wr_dst  = reg_wr && hit(reg_addr, c, OFF_DST);
    assign wr_ctrl = reg_wr && hit(reg_addr, c, OFF_CTRL);

    // selected trigger: peripheral, pin edge or software write
    assign trig[c] = (wr_ctrl && reg_wdata[B_SWTRIG]) // see [RQ3]
                   || ((sel[c] < SEL_W'(NUM_SRC)) && mask[sel[c]] && events[sel[c]]);

    // several requests before the start clear collapse into one transfer,
    // so software must not count requests to predict transfers
    // request bit: hardware set wins over start and software clear
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        req[c] <= 1'b0;
      end else if (trig[c]) begin
        req[c] <= 1'b1; // see [RQ19] and [RQ6]
      end else if (start[c] || (wr_ctrl && !reg_wdata[B_REQ])) begin
        req[c] <= 1'b0; // see [RQ19]
      end
    end

    // pointer registers; fixed ones locked while enabled
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        src_ptr[c] <= '0;
        dst_ptr[c] <= '0;
      end else begin
        if (wr_src && (src_fwd[c] || !en[c])) src_ptr[c] <= reg_wdata[ADDR_W-1:0]; // see [RQ17]
        if (wr_dst && (dst_fwd[c] || !en[c])) dst_ptr[c] <= reg_wdata[ADDR_W-1:0]; // see [RQ17]
      end
    end

    // reload value and source selection
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        reload[c] <= '0;
        sel[c]    <= SRC_SOFT;
      end else begin
        if (reg_wr && hit(reg_addr, c, OFF_RELOAD)) reload[c] <= reg_wdata[CNT_W-1:0];
        if (reg_wr && hit(reg_addr, c, OFF_SEL))    sel[c]    <= reg_wdata[SEL_W-1:0];
      end
    end

    // the live pointer is loaded from the programmed pointer only at the
    // first start after enabling; later writes to a forward pointer land
    // in the programmed copy and take effect at the next restart
    // mode bits; forward on both ends is refused by dropping destination forward
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        repeat_mode[c] <= 1'b0;
        byte_unit[c]   <= 1'b0;
        src_fwd[c]     <= 1'b0;
        dst_fwd[c]     <= 1'b0;
      end else if (wr_ctrl) begin
        repeat_mode[c] <= reg_wdata[B_REPEAT];
        byte_unit[c]   <= reg_wdata[B_BYTE]; // see [RQ2]
        src_fwd[c]     <= reg_wdata[B_SRC_FWD];
        dst_fwd[c]     <= reg_wdata[B_DST_FWD] && !reg_wdata[B_SRC_FWD]; // see [RQ8]
      end
    end

    // enable, restart flag, live pointer and counter
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        en[c]      <= 1'b0;
        first[c]   <= 1'b0;
        fwd_ptr[c] <= '0;
        count[c]   <= '0;
      end else begin
        if (start[c] && first[c]) begin
          fwd_ptr[c] <= pick_fwd; // see [RQ16]
          count[c]   <= reload[c];
          first[c]   <= 1'b0;
        end
        // a counter at zero marks the last unit of the run: a reload
        // value of n therefore yields n plus one units
        if (done[c]) begin
          fwd_ptr[c] <= fwd_ptr[c] + (byte_unit[c] ? STEP_BYTE : STEP_WORD); // see [RQ21]
          if (count[c] == '0) begin
            if (repeat_mode[c]) begin
              count[c] <= reload[c]; // see [RQ15]
            end else begin
              en[c] <= 1'b0; // see [RQ14]
            end
          end else begin
            count[c] <= count[c] - 1'b1; // see [RQ10]
          end
        end
        // software write of the enable overrides, a one restarts
        if (wr_ctrl) begin
          en[c]    <= reg_wdata[B_EN];
          first[c] <= reg_wdata[B_EN]; // see [RQ20]
        end
      end
    end
  end

  // a protected address is driven on mem_addr but never strobed: a skipped read yields
  // zero and a skipped write is dropped silently; this keeps a runaway
  // pointer from rewriting the channel registers
  // transfer engine: steal one read and one write cycle per unit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      cur_ch    <= 1'b0;
      cpu_hold  <= 1'b0;
      mem_addr  <= '0;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_byte  <= 1'b0;
      wr_addr   <= '0;
      data_hold <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (pick_any) begin
            state    <= ST_READ;
            cur_ch   <= pick_ch;
            cpu_hold <= 1'b1; // see [RQ1]
            mem_addr <= pick_src;
            mem_rd   <= !is_prot(pick_src); // see [RQ9]
            mem_byte <= byte_unit[pick_ch];
            wr_addr  <= pick_dst;
          end
        end
        ST_READ: begin
          if (mem_ack || !mem_rd) begin
            state     <= ST_WRITE;
            data_hold <= mem_rd ? mem_rdata : '0;
            mem_rd    <= 1'b0;
            mem_addr  <= wr_addr;
            mem_wr    <= !is_prot(wr_addr); // see [RQ9]
          end
        end
        ST_WRITE: begin
          if (mem_ack || !mem_wr) begin
            state    <= ST_IDLE;
            mem_wr   <= 1'b0;
            cpu_hold <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // write data follows the captured read data
  assign mem_wdata = data_hold;

  // the read mux samples live state; a forward pointer read while the
  // channel runs may change between two reads of the same register
  // register read: one cycle later; live pointer while enabled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        if (hit(reg_addr, c, OFF_SRC)) begin
          reg_rdata <= 32'(en[c] && src_fwd[c] && !first[c] ? fwd_ptr[c] : src_ptr[c]); // see [RQ18]
        end
        if (hit(reg_addr, c, OFF_DST)) begin
          reg_rdata <= 32'(en[c] && dst_fwd[c] && !first[c] ? fwd_ptr[c] : dst_ptr[c]); // see [RQ18]
        end
        if (hit(reg_addr, c, OFF_RELOAD)) reg_rdata <= 32'(reload[c]);
        if (hit(reg_addr, c, OFF_COUNT))  reg_rdata <= 32'(count[c]);
        if (hit(reg_addr, c, OFF_SEL))    reg_rdata <= 32'(sel[c]);
        if (hit(reg_addr, c, OFF_CTRL)) begin
          reg_rdata <= 32'({req[c], dst_fwd[c], src_fwd[c], byte_unit[c],
                            repeat_mode[c], en[c]});
        end
      end
    end
  end

  // requests ignore any cpu interrupt mask; no interrupt flag is touched
  // interrupt state is neither read nor written here (see [RQ4])

endmodule : tcd_dma
`default_nettype wire

// file: tb/tcd_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module tcd_mem_model
  import tcd_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_wdata,
  input  wire logic              mem_rd,
  input  wire logic              mem_wr,
  input  wire logic              mem_byte,
  output logic      [DATA_W-1:0] mem_rdata,
  output logic                   mem_ack
);
  logic [35:0] wq[$];
  int          wait_n;

  // address pattern in the ack cycle, inverted outside it so stale data never matches
  assign mem_rdata = mem_ack ? {mem_addr[7:0] ^ 8'h5a, mem_addr[7:0]}
                             : ~{mem_addr[7:0] ^ 8'h5a, mem_addr[7:0]};

  // ack after zero to two wait cycles, log every completed write
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_n  <= 0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      wait_n  <= $urandom % 3;
      if (mem_wr) wq.push_back({mem_addr, mem_byte ? {8'h00, mem_wdata[7:0]} : mem_wdata});
    end else if (mem_rd || mem_wr) begin
      if (wait_n == 0) mem_ack <= 1'b1;
      else wait_n <= wait_n - 1;
    end
  end
endmodule : tcd_mem_model
`default_nettype wire

// file: tb/tcd_dma_props.sv
`timescale 1ns/10ps
`default_nettype none
module tcd_dma_props
  import tcd_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              cpu_hold,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  input wire logic              mem_rd,
  input wire logic              mem_wr,
  input wire logic              mem_byte,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic              mem_ack
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // bus ownership and strobe discipline
  AST_ONE_STROBE: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");
  AST_RD_HOLD: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
    else $error("read dropped before ack");
  AST_RD_THEN_WR: assert property (mem_rd && mem_ack |=> !mem_rd && (mem_wr || (mem_addr >= PROT_LO && mem_addr <= PROT_HI)))
    else $error("no write after read ack");
  AST_WDATA: assert property (mem_rd && mem_ack && !mem_byte |=> mem_wdata == $past(mem_rdata))
    else $error("written data differs from read data");
  AST_BUS_OWNED: assert property (mem_rd || mem_wr |-> cpu_hold)
    else $error("strobe without bus hold");
  AST_PROT: assert property (mem_rd || mem_wr |-> mem_addr < PROT_LO || mem_addr > PROT_HI)
    else $error("access inside protected range");
  AST_WR_DONE: assert property (mem_wr && mem_ack |=> !mem_wr && !cpu_hold)
    else $error("bus kept after write ack");
  AST_WR_HOLD: assert property (mem_wr && !mem_ack |=> mem_wr && $stable(mem_wdata))
    else $error("write changed before ack");
  AST_START: assert property ($rose(cpu_hold) |-> ##[0:1] (mem_rd || mem_wr))
    else $error("bus held without strobe");

  // main scenarios
  cover property (mem_rd && mem_ack);
  cover property (mem_wr && mem_ack && mem_byte);
  cover property ($fell(cpu_hold));
endmodule : tcd_dma_props
`default_nettype wire

// file: tb/tcd_dma_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tcd_dma_tb
  import tcd_pkg::*;
;
  logic              clk_sys, rst, reg_wr, reg_rd, cpu_hold, mem_rd, mem_wr, mem_byte, mem_ack;
  logic              ext_interrupt_pin_a, ext_interrupt_pin_b;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata;
  logic [18:0]       periph_irq;
  logic [19:0]       mem_addr, sa;
  logic [15:0]       mem_wdata, mem_rdata;
  int                fails = 0;
  int                n_checks = 0;
  int                cycles = 0;
  int                k;

  tcd_dma u_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_interrupt_pin_a, .ext_interrupt_pin_b, .periph_irq, .cpu_hold, .mem_addr,
    .mem_wdata, .mem_rd, .mem_wr, .mem_byte, .mem_rdata, .mem_ack);
  tcd_mem_model u_mem (.clk_sys, .rst, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_byte,
    .mem_rdata, .mem_ack);

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] ra(input int c, input logic [7:0] off);
    return off + (c == 1 ? CH_STRIDE : 8'h00);
  endfunction : ra
  function automatic logic [15:0] pat(input logic [19:0] a);
    return {a[7:0] ^ 8'h5a, a[7:0]};
  endfunction : pat
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk({4'h0, reg_rdata}, {4'h0, exp});
  endtask : rd_chk
  task automatic cfg(input int c, input logic [19:0] s, input logic [19:0] d,
                     input logic [15:0] n, input logic [4:0] sel, input logic [6:0] ctl);
    wr(ra(c, OFF_CTRL), 32'h0);
    wr(ra(c, OFF_SRC), {12'h0, s});
    wr(ra(c, OFF_DST), {12'h0, d});
    wr(ra(c, OFF_RELOAD), {16'h0, n});
    wr(ra(c, OFF_SEL), {27'h0, sel});
    wr(ra(c, OFF_CTRL), {25'h0, ctl});
  endtask : cfg
  task automatic pulse(input int i);
    @(posedge clk_sys);
    periph_irq[i] <= 1'b1;
    @(posedge clk_sys);
    periph_irq[i] <= 1'b0;
  endtask : pulse
  // wait until the bus has been free for eight cycles
  task automatic settle();
    int q = 0;
    repeat (400) begin
      @(posedge clk_sys);
      q = (cpu_hold === 1'b0) ? q + 1 : 0;
      if (q == 8) break;
    end
  endtask : settle
  task automatic exp_wr(input logic [19:0] a, input logic [15:0] d);
    chk(u_mem.wq.size() > 0 ? u_mem.wq.pop_front() : 36'hf_ffff_ffff, {a, d});
  endtask : exp_wr

  // main sequence
  initial begin
    rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
    ext_interrupt_pin_a = 1'b1; ext_interrupt_pin_b = 1'b1; periph_irq = '0;
    k = $urandom(32'h972e);
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(ra(0, OFF_CTRL), 32'h0);
    rd_chk(8'h18, 32'h0);
    $display("test reset done");
    // single mode: fixed word source, forward destination, three units
    cfg(0, 20'h01000, 20'h02000, 16'h0002, 5'h04, 7'h11);
    pulse(0);
    settle();
    exp_wr(20'h02000, pat(20'h01000));
    rd_chk(ra(0, OFF_DST), 32'h02002);
    rd_chk(ra(0, OFF_COUNT), 32'h1);
    wr(ra(0, OFF_SRC), 32'h01500);
    rd_chk(ra(0, OFF_SRC), 32'h01000);
    for (int i = 0; i < 2; i++) begin
      pulse(0);
      settle();
      exp_wr(20'h02002 + 20'(2 * i), pat(20'h01000));
    end
    rd_chk(ra(0, OFF_CTRL), 32'h10);
    $display("test single done");
    // both directions forward keeps only the source one
    wr(ra(1, OFF_CTRL), 32'h18);
    rd_chk(ra(1, OFF_CTRL), 32'h08);
    // request latches while disabled, software clears it
    pulse(0);
    settle();
    chk(36'(u_mem.wq.size()), 36'h0);
    rd_chk(ra(0, OFF_CTRL), 32'h30);
    wr(ra(0, OFF_CTRL), 32'h10);
    rd_chk(ra(0, OFF_CTRL), 32'h10);
    $display("test request done");
    // repeat mode, byte units, random source and random peripheral
    k = 1 + $urandom % 18;
    sa = 20'h03000 + 20'($urandom % 256);
    cfg(1, sa, 20'h04000, 16'h0001, 5'(4 + k), 7'h0f);
    for (int i = 0; i < 3; i++) begin
      pulse(k);
      settle();
      exp_wr(20'h04000, pat(sa + 20'(i)) & 16'h00ff);
    end
    rd_chk(ra(1, OFF_CTRL), 32'h0f);
    rd_chk(ra(1, OFF_SRC), {12'h0, sa + 20'h3});
    $display("test repeat done");
    // one request shared by both channels
    cfg(1, 20'h01100, 20'h05000, 16'h0, 5'h04, 7'h11);
    cfg(0, 20'h01200, 20'h06000, 16'h0, 5'h04, 7'h11);
    pulse(0);
    settle();
    exp_wr(20'h06000, pat(20'h01200));
    exp_wr(20'h05000, pat(20'h01100));
    $display("test priority done");
    // pin falling edges, one from a protected source
    cfg(0, 20'h00030, 20'h07000, 16'h0, 5'h01, 7'h11);
    cfg(1, 20'h01300, 20'h08000, 16'h0, 5'h03, 7'h11);
    ext_interrupt_pin_a <= 1'b0;
    ext_interrupt_pin_b <= 1'b0;
    repeat (6) @(posedge clk_sys);
    ext_interrupt_pin_a <= 1'b1;
    ext_interrupt_pin_b <= 1'b1;
    settle();
    exp_wr(20'h07000, 16'h0);
    exp_wr(20'h08000, pat(20'h01300));
    chk(36'(u_mem.wq.size()), 36'h0);
    $display("test pins done");
    // software trigger, then a second enable write restarts the run
    cfg(0, 20'h01400, 20'h09000, 16'h1, 5'h00, 7'h11);
    wr(ra(0, OFF_CTRL), 32'h51);
    settle();
    exp_wr(20'h09000, pat(20'h01400));
    wr(ra(0, OFF_CTRL), 32'h51);
    settle();
    exp_wr(20'h09000, pat(20'h01400));
    rd_chk(ra(0, OFF_COUNT), 32'h0);
    // pin a on both edges gives two units
    cfg(0, 20'h01600, 20'h0a000, 16'h1, 5'h02, 7'h11);
    ext_interrupt_pin_a <= 1'b0;
    repeat (6) @(posedge clk_sys);
    ext_interrupt_pin_a <= 1'b1;
    settle();
    exp_wr(20'h0a000, pat(20'h01600));
    exp_wr(20'h0a002, pat(20'h01600));
    $display("test trigger done");
    finish_test();
  end
endmodule : tcd_dma_tb

bind tcd_dma tcd_dma_props u_props (.clk_sys, .rst, .cpu_hold, .mem_addr, .mem_wdata, .mem_rd,
  .mem_wr, .mem_byte, .mem_rdata, .mem_ack);
`default_nettype wire
